/* File: hw/uoesc_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "uoesc_defs.vh"

module uoesc_ctrl (
    input wire core_clk,
    input wire rst_b,
    // firmware indirect register port
    input wire [5:0] idx_addr,
    input wire idx_wr,
    input wire idx_rd,
    input wire [7:0] idx_wdata,
    output reg [7:0] idx_rdata,
    // bus event strobes from the serial engine
    input wire sof_evt,
    input wire bus_reset_evt,
    input wire resume_evt,
    input wire suspend_evt,
    input wire suspended,
    input wire suspend_det_en,
    // endpoint configuration
    input wire iso_mode,
    input wire double_buffer_enable,
    // received out data packet
    input wire rx_start,
    input wire rx_byte_vld,
    input wire [7:0] rx_byte,
    input wire rx_end,
    input wire rx_bad,
    input wire rx_pid_data1,
    // handshake answer
    output reg hs_vld,
    output reg [1:0] hs_code,
    output wire expected_toggle,
    output wire packet_ready_flag
);
    // flush sequencer states
    localparam FL_IDLE = 1'b0;
    localparam FL_BUSY = 1'b1;

    reg sof_flag_r, bus_reset_flag_r, resume_flag_r, suspend_flag_r;
    reg stall_sent_flag_r, send_stall_ctrl_r, data_error_flag_r;
    reg overrun_flag_r, toggle_r, drop_r, fl_state_r;
    wire [1:0] pkt_cnt;
    wire [7:0] fifo_rd_data;
    wire fifo_full_status;
    wire wr_cm, wr_cs, rd_cm, rd_fifo, stall_act, rx_ok;
    wire commit, abort, pop, sw_pop, fl_req;
    wire clr_stsent, clr_derr, clr_ovr;

    assign wr_cm = idx_wr && idx_addr == `UOESC_ADDR_COMMON;
    assign wr_cs = idx_wr && idx_addr == `UOESC_ADDR_OUTCSR;
    assign rd_cm = idx_rd && idx_addr == `UOESC_ADDR_COMMON;
    assign rd_fifo = idx_rd && idx_addr == `UOESC_ADDR_FIFO;

    assign fifo_full_status = double_buffer_enable ? (pkt_cnt == 2'h2)
                                                   : (pkt_cnt != 2'h0);
    assign packet_ready_flag = pkt_cnt != 2'h0;
    assign stall_act = send_stall_ctrl_r && !iso_mode;
    assign rx_ok = !rx_bad && (iso_mode || rx_pid_data1 == toggle_r);
    // a repeated packet with the wrong toggle is acked but not stored
    assign commit = rx_end && !drop_r && rx_ok && !stall_act;
    assign abort = rx_end && !commit;
    // software clears packet-ready by writing zero to it
    assign sw_pop = wr_cs && !idx_wdata[`UOESC_CS_RDY] && packet_ready_flag;
    assign fl_req = wr_cs && idx_wdata[`UOESC_CS_FLUSH];
    assign pop = sw_pop || fl_state_r == FL_BUSY;

    // software clears a sticky flag by writing zero to its bit
    assign clr_stsent = wr_cs && !idx_wdata[`UOESC_CS_STSENT];
    assign clr_derr = wr_cs && !idx_wdata[`UOESC_CS_DERR];
    assign clr_ovr = wr_cs && !idx_wdata[`UOESC_CS_OVR];

    uoesc_out_fifo u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_vld(rx_byte_vld && !drop_r),
        .wr_data(rx_byte),
        .pkt_commit(commit),
        .pkt_abort(abort),
        .rd_byte(rd_fifo),
        .pop(pop),
        .rd_data(fifo_rd_data),
        .pkt_cnt(pkt_cnt)
    );

    assign expected_toggle = toggle_r;

    // common events: set wins over the clear caused by a read
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sof_flag_r <= 1'b0;
            bus_reset_flag_r <= 1'b0;
            resume_flag_r <= 1'b0;
            suspend_flag_r <= 1'b0;
        end else begin
            sof_flag_r <= sof_evt | (sof_flag_r & !rd_cm);
            bus_reset_flag_r <= bus_reset_evt | (bus_reset_flag_r & !rd_cm);
            resume_flag_r <= (resume_evt & suspended)
                | (resume_flag_r & !rd_cm);
            suspend_flag_r <= (suspend_evt & suspend_det_en)
                | (suspend_flag_r & !rd_cm);
        end
    end

    // flush takes one cycle in the busy state, then the bit drops
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fl_state_r <= FL_IDLE;
        end else begin
            case (fl_state_r)
                FL_IDLE: begin
                    if (fl_req && packet_ready_flag && !sw_pop)
                        fl_state_r <= FL_BUSY;
                end
                FL_BUSY: fl_state_r <= FL_IDLE;
                default: fl_state_r <= FL_IDLE;
            endcase
        end
    end

    // packet intake decision at rx start: full fifo drops the whole packet
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            drop_r <= 1'b0;
        else if (rx_start)
            drop_r <= fifo_full_status || stall_act;
    end

    // expected toggle: a clear request beats a flip in the same cycle
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            toggle_r <= 1'b0;
        else if (wr_cs && idx_wdata[`UOESC_CS_CLR_TOG])
            toggle_r <= 1'b0;
        else if (commit && !iso_mode)
            toggle_r <= ~toggle_r;
    end

    // send-stall is a plain level owned by software
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            send_stall_ctrl_r <= 1'b0;
        else if (wr_cs)
            send_stall_ctrl_r <= idx_wdata[`UOESC_CS_SEND_STALL];
    end

    // stall-sent: a stalled packet end sets it, set beats the clear
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            stall_sent_flag_r <= 1'b0;
        else
            stall_sent_flag_r <= (rx_end && stall_act)
                | (stall_sent_flag_r & !clr_stsent);
    end

    // data error only counts in isochronous mode
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            data_error_flag_r <= 1'b0;
        else
            data_error_flag_r <= (rx_end && iso_mode && rx_bad)
                | (data_error_flag_r & !clr_derr);
    end

    // overrun: an isochronous packet dropped for lack of room, sticky until cleared
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            overrun_flag_r <= 1'b0;
        else
            overrun_flag_r <= (rx_end && iso_mode && drop_r)
                | (overrun_flag_r & !clr_ovr);
    end

    // handshake pulse one cycle after packet end; iso gets none, a bad packet only a stall
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_vld <= 1'b0;
            hs_code <= 2'h0;
        end else begin
            hs_vld <= rx_end && !iso_mode && (stall_act || !rx_bad);
            if (stall_act)
                hs_code <= `UOESC_HS_STALL;
            else if (drop_r)
                hs_code <= `UOESC_HS_NAK;
            else
                hs_code <= `UOESC_HS_ACK;
        end
    end

    // read field map; unlisted bits and addresses stay zero
    reg [7:0] rdata_nxt;
    always @* begin
        rdata_nxt = `UOESC_RST_BYTE;
        case (idx_addr)
            `UOESC_ADDR_COMMON: begin
                rdata_nxt[`UOESC_CM_SOF] = sof_flag_r;
                rdata_nxt[`UOESC_CM_RST] = bus_reset_flag_r;
                rdata_nxt[`UOESC_CM_RSU] = resume_flag_r;
                rdata_nxt[`UOESC_CM_SUS] = suspend_flag_r;
            end
            `UOESC_ADDR_OUTCSR: begin // clear-toggle bit left zero
                rdata_nxt[`UOESC_CS_STSENT] = stall_sent_flag_r;
                rdata_nxt[`UOESC_CS_SEND_STALL] = send_stall_ctrl_r;
                rdata_nxt[`UOESC_CS_FLUSH] = fl_state_r == FL_BUSY;
                rdata_nxt[`UOESC_CS_DERR] = data_error_flag_r;
                rdata_nxt[`UOESC_CS_OVR] = overrun_flag_r;
                rdata_nxt[`UOESC_CS_FULL] = fifo_full_status;
                rdata_nxt[`UOESC_CS_RDY] = packet_ready_flag;
            end
            `UOESC_ADDR_FIFO: rdata_nxt = fifo_rd_data;
            default: rdata_nxt = `UOESC_RST_BYTE;
        endcase
    end

    // read data, registered one cycle after the read strobe
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            idx_rdata <= `UOESC_RST_BYTE;
        else if (idx_rd)
            idx_rdata <= rdata_nxt;
    end
endmodule // uoesc_ctrl
`default_nettype wire

/* File: hw/uoesc_defs.vh */
// Summary of operation
// - clear-toggle write zeroes data toggle, reads zero
// - stall-sent set on STALL sent, software clears
// - send-stall held high answers STALL handshakes
// - send-stall ignored in isochronous mode
// - flush write discards oldest unread packet
// - flush moves read pointer to next packet, clears packet-ready if none left
// - flush bit self-clears when removal completes
// - overrun set, packet lost when FIFO full
// - overrun isochronous only, sticky until cleared
// - full at two packets double, one single
// - resume set while suspended, read clears
`ifndef UOESC_DEFS_VH
`define UOESC_DEFS_VH

// indirect register addresses
`define UOESC_ADDR_COMMON 6'h06
`define UOESC_ADDR_OUTCSR 6'h14
`define UOESC_ADDR_FIFO 6'h20

// common event register fields
`define UOESC_CM_SOF 3
`define UOESC_CM_RST 2
`define UOESC_CM_RSU 1
`define UOESC_CM_SUS 0

// out endpoint control low fields
`define UOESC_CS_CLR_TOG 7
`define UOESC_CS_STSENT 6
`define UOESC_CS_SEND_STALL 5
`define UOESC_CS_FLUSH 4
`define UOESC_CS_DERR 3
`define UOESC_CS_OVR 2
`define UOESC_CS_FULL 1
`define UOESC_CS_RDY 0

`define UOESC_RST_BYTE 8'h00

// handshake codes towards the serial engine
`define UOESC_HS_ACK 2'h1
`define UOESC_HS_NAK 2'h2
`define UOESC_HS_STALL 2'h3

// fifo geometry: two packets of up to 64 bytes
`define UOESC_FIFO_AW 7
`define UOESC_FIFO_DEPTH 128
`define UOESC_PKT_LW 7

`endif

/* File: hw/uoesc_out_fifo.v */
`timescale 1ns/10ps
`default_nettype none
`include "uoesc_defs.vh"

module uoesc_out_fifo (
    input wire core_clk,
    input wire rst_b,
    input wire wr_vld,
    input wire [7:0] wr_data,
    input wire pkt_commit,
    input wire pkt_abort,
    input wire rd_byte,
    input wire pop,
    output reg [7:0] rd_data,
    output wire [1:0] pkt_cnt
);
    reg [7:0] mem [0:`UOESC_FIFO_DEPTH-1];
    reg [`UOESC_FIFO_AW-1:0] wp_r, wstart_r, rp_r, head_r;
    reg [`UOESC_PKT_LW-1:0] len0_r, len1_r;
    reg [1:0] cnt_r;
    wire [`UOESC_PKT_LW-1:0] cur_len;

    assign pkt_cnt = cnt_r;
    assign cur_len = wp_r - wstart_r;

    // data store has no reset, pointers do
    always @(posedge core_clk) begin
        if (wr_vld)
            mem[wp_r] <= wr_data;
    end

    // byte at the read pointer shows at once so a register read can take it
    always @* begin
        rd_data = mem[rp_r];
    end

    // an aborted packet rewinds so a bad frame never reaches software
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= 7'h00;
            wstart_r <= 7'h00;
            rp_r <= 7'h00;
            head_r <= 7'h00;
            len0_r <= 7'h00;
            len1_r <= 7'h00;
            cnt_r <= 2'h0;
        end else begin
            if (wr_vld)
                wp_r <= wp_r + 7'h01;
            if (pkt_abort)
                wp_r <= wstart_r;
            else if (pkt_commit)
                wstart_r <= wp_r;
            // popping moves head and read pointer to next packet start
            if (pop && cnt_r != 2'h0) begin
                head_r <= head_r + len0_r;
                rp_r <= head_r + len0_r;
                len0_r <= (pkt_commit && cnt_r == 2'h1) ? cur_len : len1_r;
            end else if (rd_byte) begin
                rp_r <= rp_r + 7'h01;
            end
            if (pkt_commit && !(pop && cnt_r != 2'h0)) begin
                if (cnt_r == 2'h0)
                    len0_r <= cur_len;
                else
                    len1_r <= cur_len;
            end
            case ({pkt_commit, pop && cnt_r != 2'h0})
                2'b10: cnt_r <= cnt_r + 2'h1;
                2'b01: cnt_r <= cnt_r - 2'h1;
                default: cnt_r <= cnt_r;
            endcase
        end
    end
endmodule // uoesc_out_fifo
`default_nettype wire

/* File: verif/uoesc_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module uoesc_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [5:0] idx_addr,
    input wire logic idx_wr,
    input wire logic idx_rd,
    input wire logic [7:0] idx_wdata,
    input wire logic [7:0] idx_rdata,
    input wire logic sof_evt,
    input wire logic bus_reset_evt,
    input wire logic resume_evt,
    input wire logic suspend_evt,
    input wire logic iso_mode,
    input wire logic rx_end,
    input wire logic rx_bad,
    input wire logic hs_vld,
    input wire logic expected_toggle,
    input wire logic packet_ready_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // event read with no new event landing, since a set beats the clear
    sequence quiet_rd;
        idx_rd && idx_addr == 6'h06 && !(sof_evt || bus_reset_evt ||
            resume_evt || suspend_evt);
    endsequence
    sequence evt_quiet;
        !(sof_evt || bus_reset_evt || resume_evt || suspend_evt);
    endsequence
    sequence csr_rd;
        idx_rd && idx_addr == 6'h14;
    endsequence
    hs_pulse_a: assert property (hs_vld |=> !hs_vld)
        else $error("handshake held too long");
    hs_cause_a: assert property (hs_vld |-> $past(rx_end))
        else $error("handshake without packet end");
    iso_quiet_a: assert property (rx_end && iso_mode |=> !hs_vld)
        else $error("handshake in isochronous mode");
    rdy_cause_a: assert property (
        $rose(packet_ready_flag) |-> $past(rx_end))
        else $error("ready without packet end");
    rdy_bad_a: assert property (
        rx_end && rx_bad && !packet_ready_flag |=> !packet_ready_flag)
        else $error("bad packet marked ready");
    tog_clr_a: assert property (
        idx_wr && idx_addr == 6'h14 && idx_wdata[7] && !rx_end
        |=> !expected_toggle)
        else $error("toggle not cleared");
    clear_toggle_rd_a: assert property (csr_rd |=> !idx_rdata[7])
        else $error("clear toggle reads one");
    cm_clear_a: assert property (
        quiet_rd ##1 evt_quiet ##1 quiet_rd |=> idx_rdata[3:0] == 4'h0)
        else $error("event flags survive read");
    cm_resv_a: assert property (quiet_rd |=> idx_rdata[7:4] == 4'h0)
        else $error("reserved event bits set");
endmodule // uoesc_chk
bind uoesc_ctrl uoesc_chk i_chk (.*);
`default_nettype wire

/* File: verif/uoesc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module uoesc_host_model (
    input wire logic core_clk,
    output logic rx_start = 1'b0,
    output logic rx_byte_vld = 1'b0,
    output logic [7:0] rx_byte = 8'h00,
    output logic rx_end = 1'b0,
    output logic rx_bad = 1'b0,
    output logic rx_pid_data1 = 1'b0
);
    // one out data packet; idle lines flip so stale data never looks valid
    task automatic send(input int n, input logic bad, input logic pid1);
        @(posedge core_clk);
        rx_start <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            rx_start <= 1'b0;
            rx_byte_vld <= 1'b1;
            rx_byte <= 8'h5a ^ i[7:0];
        end
        @(posedge core_clk);
        rx_byte_vld <= 1'b0;
        rx_byte <= ~rx_byte;
        rx_end <= 1'b1;
        rx_bad <= bad;
        rx_pid_data1 <= pid1;
        @(posedge core_clk);
        rx_end <= 1'b0;
        rx_bad <= ~bad;
    endtask
endmodule // uoesc_host_model
`default_nettype wire

/* File: verif/uoesc_out_endpoint_status_ctrl_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module uoesc_out_endpoint_status_ctrl_bench;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] idx_addr = 6'h00;
    logic idx_wr = 1'b0;
    logic idx_rd = 1'b0;
    logic [7:0] idx_wdata = 8'h00;
    logic sof_evt = 1'b0;
    logic bus_reset_evt = 1'b0;
    logic resume_evt = 1'b0;
    logic suspend_evt = 1'b0;
    logic suspended = 1'b0;
    logic suspend_det_en = 1'b1;
    logic iso_mode = 1'b0;
    logic double_buffer_enable = 1'b0;
    wire logic rx_start, rx_byte_vld, rx_end, rx_bad, rx_pid_data1;
    wire logic hs_vld, expected_toggle, packet_ready_flag;
    wire logic [7:0] rx_byte;
    wire logic [7:0] idx_rdata;
    wire logic [1:0] hs_code;
    int err_total = 0;
    int num_checks = 0;
    uoesc_ctrl i_dut (.*);
    uoesc_host_model i_host (.*);
    // 8 ns core clock
    always #4 core_clk = ~core_clk;
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        idx_addr <= a;
        idx_wdata <= d;
        idx_wr <= 1'b1;
        @(posedge core_clk);
        idx_wr <= 1'b0;
    endtask
    // read data is registered, so look one edge after the strobe
    task rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge core_clk);
        idx_addr <= a;
        idx_rd <= 1'b1;
        @(posedge core_clk);
        idx_rd <= 1'b0;
        #1;
        chk(idx_rdata, e);
    endtask
    // e is {valid, code}; zero means no handshake expected
    task pkt(input int n, input logic bad, input logic [2:0] e);
        i_host.send(n, bad, expected_toggle);
        #1;
        chk({5'h00, hs_vld, hs_code & {2{hs_vld}}}, {5'h00, e});
    endtask
    task t_reset;
        rd(6'h06, 8'h00);
        rd(6'h14, 8'h00);
        rd(6'h3f, 8'h00);
    endtask
    // second pulse comes while awake with suspend detection off
    task t_events;
        @(posedge core_clk);
        {sof_evt, bus_reset_evt, resume_evt, suspend_evt} <= 4'hf;
        suspended <= 1'b1;
        @(posedge core_clk);
        {sof_evt, bus_reset_evt, resume_evt, suspend_evt} <= 4'h0;
        rd(6'h06, 8'h0f);
        rd(6'h06, 8'h00);
        @(posedge core_clk);
        suspended <= 1'b0;
        suspend_det_en <= 1'b0;
        {resume_evt, suspend_evt} <= 2'b11;
        @(posedge core_clk);
        {resume_evt, suspend_evt} <= 2'b00;
        suspend_det_en <= 1'b1;
        rd(6'h06, 8'h00);
    endtask
    task t_single;
        pkt(8, 1'b0, 3'b101);
        rd(6'h14, 8'h03);
        chk({7'h00, packet_ready_flag}, 8'h01);
        chk({7'h00, expected_toggle}, 8'h01);
        pkt(4, 1'b0, 3'b110);
        wr(6'h14, 8'h10);
        rd(6'h14, 8'h00);
        wr(6'h14, 8'h80);
        rd(6'h14, 8'h00);
        chk({7'h00, expected_toggle}, 8'h00);
    endtask
    // bit0 written as one so the flush alone removes a packet
    task t_double;
        @(posedge core_clk);
        double_buffer_enable <= 1'b1;
        pkt(4, 1'b0, 3'b101);
        rd(6'h14, 8'h01);
        pkt(4, 1'b0, 3'b101);
        rd(6'h14, 8'h03);
        wr(6'h14, 8'h11);
        rd(6'h14, 8'h01);
        for (int i = 0; i < 4; i++)
            rd(6'h20, 8'h5a ^ i[7:0]);
        wr(6'h14, 8'h00);
        rd(6'h14, 8'h00);
    endtask
    task t_stall;
        wr(6'h14, 8'h20);
        pkt(4, 1'b0, 3'b111);
        rd(6'h14, 8'h60);
        rd(6'h14, 8'h60);
        wr(6'h14, 8'h00);
        pkt(4, 1'b0, 3'b101);
        rd(6'h14, 8'h01);
        wr(6'h14, 8'h00);
    endtask
    task t_iso;
        @(posedge core_clk);
        iso_mode <= 1'b1;
        double_buffer_enable <= 1'b0;
        wr(6'h14, 8'h20);
        pkt(4, 1'b1, 3'b000);
        rd(6'h14, 8'h28);
        pkt(4, 1'b0, 3'b000);
        rd(6'h14, 8'h2b);
        pkt(4, 1'b0, 3'b000);
        rd(6'h14, 8'h2f);
        wr(6'h14, 8'h00);
        rd(6'h14, 8'h00);
        @(posedge core_clk);
        iso_mode <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset;
        t_events;
        t_single;
        t_double;
        t_stall;
        t_iso;
        end_of_test;
    end
    // run needs about 160 cycles; this cuts a hang at 2500
    initial begin
        #20000;
        err_total++;
        end_of_test;
    end
endmodule // uoesc_out_endpoint_status_ctrl_bench
`default_nettype wire
